// ---- hw/pccg_top.sv ----
`timescale 1ns/10ps
module pccg_top
  import pccg_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // External clock output sources from the output dividers.
  input  wire logic        aux_a_src,
  input  wire logic        aux_b_src,
  // External clock output pins.
  output logic             aux_clock_out_a,
  output logic             aux_clock_out_b,
  // Clock enables for the downstream gating cells.
  output logic [1:0]       periph_clock_en,
  output logic             core_clock_en,
  // Port unit access and filter permission.
  output logic             port_access_ok
);

  logic        rst_meta_q;
  logic        rst_sync_n;
  logic        addr_ok;
  logic        wr_pend_q;
  logic [31:0] addr_q;
  logic [1:0]  pgate_q;
  logic [1:0]  pgate_d;
  logic [1:0]  gear_q;
  logic [1:0]  gear_d;
  logic        auxb_en_q;
  logic        auxb_en_d;
  logic        auxb_app_q;
  logic [1:0]  gear_applied;
  logic [1:0]  pclk_en_q;
  logic        aux_a_q;
  logic        aux_b_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // Reset is released through two flip-flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // A transfer is taken in its address phase when selected, the bus is ready and HTRANS is NONSEQ or SEQ.
  assign addr_ok = hsel && hready && htrans[PCCG_HTRANS_ACTIVE_BIT];

  // Write address is held for the data phase that follows.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend_q <= 1'b0;
      addr_q    <= PCCG_WORD_ZERO;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        addr_q <= haddr;
      end
    end
  end

  // Next register values; only the documented field bits are stored.
  always_comb begin
    pgate_d   = pgate_q;
    gear_d    = gear_q;
    auxb_en_d = auxb_en_q;
    if (wr_pend_q) begin
      case (addr_q)
        PCCG_PGATE_ADDR: begin
          pgate_d = hwdata[PCCG_FIELD_W-1:0];
        end
        PCCG_GEAR_ADDR: begin
          gear_d = hwdata[PCCG_FIELD_W-1:0];
        end
        PCCG_AUXB_ADDR: begin
          auxb_en_d = hwdata[PCCG_AUXB_BIT];
        end
        default: begin
          pgate_d = pgate_q;
        end
      endcase
    end
  end

  // Control registers.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pgate_q   <= PCCG_PGATE_RESET;
      gear_q    <= PCCG_GEAR_RESET;
      auxb_en_q <= PCCG_AUXB_RESET;
    end else begin
      pgate_q   <= pgate_d;
      gear_q    <= gear_d;
      auxb_en_q <= auxb_en_d;
    end
  end

  // Control register read data is formed in the address phase from next values, so a read right
  // after a write to the same register sees the new contents.
  always_comb begin
    rdata_d = PCCG_WORD_ZERO;
    case (haddr)
      PCCG_PGATE_ADDR: begin
        rdata_d[PCCG_FIELD_W-1:0] = pgate_d;
      end
      PCCG_GEAR_ADDR: begin
        rdata_d[PCCG_FIELD_W-1:0] = gear_d;
      end
      PCCG_AUXB_ADDR: begin
        rdata_d[PCCG_AUXB_BIT] = auxb_en_d;
      end
      PCCG_STATUS_ADDR: begin
        rdata_d[PCCG_STAT_GEAR_LSB +: PCCG_FIELD_W]  = gear_applied;
        rdata_d[PCCG_STAT_PGATE_LSB +: PCCG_FIELD_W] = pclk_en_q;
        rdata_d[PCCG_STAT_AUXB_BIT]                  = auxb_app_q;
      end
      default: begin
        rdata_d = PCCG_WORD_ZERO;
      end
    endcase
  end

  // Read data register; unmapped addresses read zero.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q <= PCCG_WORD_ZERO;
    end else if (addr_ok && !hwrite) begin
      rdata_q <= rdata_d;
    end
  end

  // The slave never stalls and always answers OKAY.
  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = PCCG_HRESP_OKAY;

  // Each gate field bit enables its half of the peripheral tree; whole cycles only.
  for (genvar i = 0; i < PCCG_FIELD_W; i++) begin : g_pgate
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pclk_en_q[i] <= PCCG_PGATE_RESET[i];
      end else begin
        pclk_en_q[i] <= pgate_q[i];
      end
    end
  end

  assign periph_clock_en = pclk_en_q;

  // Port unit needs the full peripheral clock for access and filtering.
  assign port_access_ok = (pclk_en_q == PCCG_PGATE_ON);

  // Core gear divider.
  pccg_gear_div u_gear_div (
    .clock         (clock),
    .rst_sync_n    (rst_sync_n),
    .gear_req      (gear_q),
    .gear_applied  (gear_applied),
    .core_clock_en (core_clock_en)
  );

  // Enable for output B is taken over only while its source is low.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      auxb_app_q <= PCCG_AUXB_RESET;
    end else if (!aux_b_src) begin
      auxb_app_q <= auxb_en_q;
    end
  end

  // Output pins; output A ignores the peripheral gate entirely.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aux_a_q <= 1'b0;
      aux_b_q <= 1'b0;
    end else begin
      aux_a_q <= aux_a_src;
      aux_b_q <= aux_b_src && auxb_app_q;
    end
  end

  assign aux_clock_out_a = aux_a_q;
  assign aux_clock_out_b = aux_b_q;

  // The gate field starts out supplying the peripheral clock.
  pgate_reset_a: assert property (@(posedge clock)
    $rose(rst_sync_n) |-> (pgate_q == PCCG_PGATE_RESET && pclk_en_q == PCCG_PGATE_ON))
    else $error("Peripheral clock not supplied after reset.");

  // Writing zero to the gate field stops both halves two edges later.
  pgate_off_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (wr_pend_q && addr_q == PCCG_PGATE_ADDR && hwdata[PCCG_FIELD_W-1:0] == PCCG_PGATE_OFF)
    |=> ##1 (periph_clock_en == PCCG_PGATE_OFF && !port_access_ok))
    else $error("Peripheral clock still enabled after gate off.");

  // Writing 0x3 turns the full tree on two edges later.
  pgate_on_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (wr_pend_q && addr_q == PCCG_PGATE_ADDR && hwdata[PCCG_FIELD_W-1:0] == PCCG_PGATE_ON)
    |=> ##1 (periph_clock_en == PCCG_PGATE_ON))
    else $error("Peripheral clock not enabled after gate on.");

  // Port access follows the complete peripheral gate.
  port_access_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    port_access_ok == (periph_clock_en[0] && periph_clock_en[1]))
    else $error("Port access permission disagrees with peripheral gate.");

  // Output B is high only from a high source while its enable has been taken over.
  // The applied enable may lag the register while the source stays high, so it is checked instead.
  auxb_gate_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    aux_clock_out_b |-> $past(auxb_app_q) && $past(aux_b_src))
    else $error("Output B high without enable.");

  // Output B pulses are never cut: once high it stays as long as the source.
  auxb_whole_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (aux_clock_out_b && aux_b_src) |=> aux_clock_out_b)
    else $error("Output B pulse truncated.");

  // Output A keeps following its source whatever the gate says.
  auxa_free_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    ##1 (aux_clock_out_a == $past(aux_a_src)))
    else $error("Output A stopped by peripheral gate.");

  // Reserved bits of the gate and gear registers read as zero.
  rsvd_zero_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (addr_ok && !hwrite && (haddr == PCCG_PGATE_ADDR || haddr == PCCG_GEAR_ADDR))
    |=> (hrdata[31:2] == 30'h0000_0000))
    else $error("Reserved control bits read nonzero.");

  // The gear register resets to full speed.
  gear_reset_a: assert property (@(posedge clock)
    $rose(rst_sync_n) |-> (gear_q == PCCG_GEAR_RESET && gear_applied == PCCG_GEAR_RESET))
    else $error("Core gear not full speed after reset.");

endmodule : pccg_top

// ---- hw/pccg_pkg.sv ----
package pccg_pkg;

  // Register indices as printed; each register's byte address is four times its index.
  localparam logic [15:0] PCCG_PGATE_IDX  = 16'h5080;
  localparam logic [15:0] PCCG_GEAR_IDX   = 16'h5081;
  localparam logic [15:0] PCCG_AUXB_IDX   = 16'h5082;
  localparam logic [15:0] PCCG_STATUS_IDX = 16'h5083;
  localparam logic [31:0] PCCG_PGATE_ADDR  = {14'h0000, PCCG_PGATE_IDX, 2'h0};
  localparam logic [31:0] PCCG_GEAR_ADDR   = {14'h0000, PCCG_GEAR_IDX, 2'h0};
  localparam logic [31:0] PCCG_AUXB_ADDR   = {14'h0000, PCCG_AUXB_IDX, 2'h0};
  localparam logic [31:0] PCCG_STATUS_ADDR = {14'h0000, PCCG_STATUS_IDX, 2'h0};

  // Field widths, reset values and codes.
  localparam int          PCCG_FIELD_W     = 2;
  localparam logic [1:0]  PCCG_PGATE_RESET = 2'h3;
  localparam logic [1:0]  PCCG_PGATE_ON    = 2'h3;
  localparam logic [1:0]  PCCG_PGATE_OFF   = 2'h0;
  localparam logic [1:0]  PCCG_GEAR_RESET  = 2'h0;
  localparam logic [1:0]  PCCG_GEAR_DIV8   = 2'h3;
  localparam logic        PCCG_AUXB_RESET  = 1'h0;
  localparam int          PCCG_AUXB_BIT    = 0;

  // Status register layout.
  localparam int          PCCG_STAT_GEAR_LSB  = 0;
  localparam int          PCCG_STAT_PGATE_LSB = 2;
  localparam int          PCCG_STAT_AUXB_BIT  = 4;

  // Gear divider counter.
  localparam int          PCCG_DIV_W   = 3;
  localparam logic [2:0]  PCCG_DIV_ONE = 3'h1;
  localparam logic [2:0]  PCCG_DIV_ZERO = 3'h0;

  // AHB-Lite encodings.
  localparam int          PCCG_HTRANS_ACTIVE_BIT = 1;
  localparam logic        PCCG_HRESP_OKAY        = 1'h0;
  localparam logic [31:0] PCCG_WORD_ZERO         = 32'h0000_0000;

endpackage : pccg_pkg

// ---- hw/pccg_gear_div.sv ----
`timescale 1ns/10ps
module pccg_gear_div
  import pccg_pkg::*;
(
  // Clock and synchronised reset.
  input  wire logic       clock,
  input  wire logic       rst_sync_n,
  // Requested and applied gear.
  input  wire logic [1:0] gear_req,
  output logic      [1:0] gear_applied,
  // Core clock enable, one pulse per core clock period.
  output logic            core_clock_en
);

  logic [PCCG_DIV_W-1:0] count_q;
  logic [PCCG_DIV_W-1:0] count_d;
  logic [PCCG_DIV_W-1:0] limit;
  logic                  wrap;
  logic [1:0]            gear_q;
  logic                  en_q;

  // The period length follows the applied gear, never the requested one.
  assign limit   = (PCCG_DIV_ONE << gear_q) - PCCG_DIV_ONE;
  assign wrap    = (count_q == limit);
  assign count_d = wrap ? PCCG_DIV_ZERO : count_q + PCCG_DIV_ONE;

  // Period counter.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_q <= PCCG_DIV_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // A new gear is taken only at a period boundary, so no period is cut short.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gear_q <= PCCG_GEAR_RESET;
    end else if (wrap) begin
      gear_q <= gear_req;
    end
  end

  // One enable pulse marks the start of each core period.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      en_q <= 1'b0;
    end else begin
      en_q <= wrap;
    end
  end

  assign gear_applied  = gear_q;
  assign core_clock_en = en_q;

  // At the slowest gear the core sees exactly one pulse in eight cycles.
  gear_div8_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (en_q && gear_q == PCCG_GEAR_DIV8) |=> !en_q [*7] ##1 en_q)
    else $error("Core enable spacing wrong at divide by eight.");

  // The applied gear only moves at the start of a core period.
  gear_switch_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !$stable(gear_q) |-> en_q)
    else $error("Core gear changed inside a core period.");

endmodule : pccg_gear_div

// ---- verif/pccg_top_test.sv ----
`timescale 1ns/10ps
module pccg_top_test
  import pccg_pkg::*;
;
  logic        clock, rst_n, hsel, hwrite, aux_a_src, aux_b_src, hreadyout, hresp;
  logic        aux_clock_out_a, aux_clock_out_b, core_clock_en, port_access_ok;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, periph_clock_en;
  logic [2:0]  hsize;
  logic        rd_dph_q, a_prev, b_prev, chk_aux, b_en_exp;
  int          fail_count, cmp_count;
  logic [31:0] exp_q[$];
  string       name_q[$];

  pccg_top DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .aux_a_src(aux_a_src), .aux_b_src(aux_b_src),
    .aux_clock_out_a(aux_clock_out_a), .aux_clock_out_b(aux_clock_out_b),
    .periph_clock_en(periph_clock_en), .core_clock_en(core_clock_en), .port_access_ok(port_access_ok));

  // The system clock runs at 100 MHz.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  // One single word transfer; the slave may stretch either phase.
  task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    haddr  <= addr;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask : bus_xfer

  // The expected word is noted before the read so the monitor can compare it.
  task automatic reg_read(input string name, input logic [31:0] addr, input logic [31:0] exp);
    exp_q.push_back(exp);
    name_q.push_back(name);
    bus_xfer(1'b0, addr, 32'h0000_0000);
  endtask : reg_read

  task automatic set_gate(input logic [1:0] code);
    bus_xfer(1'b1, PCCG_PGATE_ADDR, {30'($urandom), code});
    repeat (2) @(posedge clock);
    @(negedge clock);
    check_bit("port_access_ok", code == 2'h3, port_access_ok);
    check_word("periph_clock_en", {30'h0, code}, {30'h0, periph_clock_en});
    reg_read("gate", PCCG_PGATE_ADDR, {30'h0, code});
  endtask : set_gate

  // Measures the distance between two core clock enables after a gear change.
  task automatic check_gear(input logic [1:0] g);
    int n;
    bus_xfer(1'b1, PCCG_GEAR_ADDR, {30'($urandom), g});
    repeat (20) @(negedge clock);
    n = 0;
    while (core_clock_en !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (core_clock_en !== 1'b1 && n < 20);
    check_word("core spacing", 32'(1 << g), 32'(n));
    reg_read("gear", PCCG_GEAR_ADDR, {30'h0, g});
  endtask : check_gear

  // Read data is compared in the cycle that ends the data phase.
  always @(posedge clock) begin
    if (rd_dph_q && hreadyout === 1'b1) begin
      check_word(name_q.pop_front(), exp_q.pop_front(), hrdata);
      check_bit("hresp", PCCG_HRESP_OKAY, hresp);
    end
    rd_dph_q <= hsel && htrans[1] && hreadyout && !hwrite && rst_n;
  end

  // Random source clocks feed both external outputs; the last values are kept for checking.
  always @(posedge clock) begin
    a_prev = aux_a_src;
    b_prev = aux_b_src;
    aux_a_src <= 1'($urandom);
    aux_b_src <= 1'($urandom);
  end

  // Both external outputs follow their sources one cycle late, output B only when enabled.
  always @(negedge clock) begin
    if (chk_aux) begin
      check_bit("aux_clock_out_a", a_prev, aux_clock_out_a);
      check_bit("aux_clock_out_b", b_prev & b_en_exp, aux_clock_out_b);
    end
  end

  // A hang ends the run as a failure.
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'h2730_606a));
    {rst_n, hsel, hwrite, aux_a_src, aux_b_src, rd_dph_q, chk_aux, b_en_exp} = 8'h40;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check_word("periph_clock_en", 32'h0000_0003, {30'h0, periph_clock_en});
    reg_read("gate", PCCG_PGATE_ADDR, 32'h0000_0003);
    reg_read("gear", PCCG_GEAR_ADDR, 32'h0000_0000);
    reg_read("auxb", PCCG_AUXB_ADDR, 32'h0000_0000);
    reg_read("status", PCCG_STATUS_ADDR, 32'h0000_000C);
    chk_aux = 1'b1;
    set_gate(2'h0);
    for (int g = 0; g < 4; g++) begin
      check_gear(2'(g));
    end
    reg_read("status", PCCG_STATUS_ADDR, 32'h0000_0003);
    set_gate(2'h3);
    chk_aux = 1'b0;
    bus_xfer(1'b1, PCCG_AUXB_ADDR, {31'($urandom), 1'b1});
    repeat (16) @(posedge clock);
    b_en_exp = 1'b1;
    chk_aux = 1'b1;
    repeat (30) @(posedge clock);
    reg_read("auxb", PCCG_AUXB_ADDR, 32'h0000_0001);
    reg_read("status", PCCG_STATUS_ADDR, 32'h0000_001F);
    chk_aux = 1'b0;
    bus_xfer(1'b1, PCCG_AUXB_ADDR, 32'hFFFF_FFFE);
    repeat (16) @(posedge clock);
    b_en_exp = 1'b0;
    chk_aux = 1'b1;
    repeat (20) @(posedge clock);
    bus_xfer(1'b1, PCCG_STATUS_ADDR, 32'h0000_0000);
    bus_xfer(1'b1, PCCG_STATUS_ADDR + 32'h0000_0004, 32'hFFFF_FFFF);
    reg_read("status", PCCG_STATUS_ADDR, 32'h0000_000F);
    reg_read("unmapped", PCCG_STATUS_ADDR + 32'h0000_0004, 32'h0000_0000);
    check_gear(2'h0);
    finish_test();
  end
endmodule : pccg_top_test
